/* File: design/ppt_cfg.svh */
// Register offsets, field positions, reset values and counts of the port and timer block.
`ifndef PPT_CFG_SVH
`define PPT_CFG_SVH

// ==========================================================================
// Register offsets on the four-bit register select
`define PPT_OFS_PORT_A_DATA 4'h0
`define PPT_OFS_PORT_B_DATA 4'h1
`define PPT_OFS_PORT_A_DIR  4'h2
`define PPT_OFS_PORT_B_DIR  4'h3
`define PPT_OFS_TA_LOW      4'h4
`define PPT_OFS_TA_HIGH     4'h5
`define PPT_OFS_TB_LOW      4'h6
`define PPT_OFS_TB_HIGH     4'h7
`define PPT_OFS_IRQ         4'hD
`define PPT_OFS_CTRL_A      4'hE
`define PPT_OFS_CTRL_B      4'hF

// ==========================================================================
// Timer control fields
`define PPT_CTL_RUN     0
`define PPT_CTL_PORTOUT 1
`define PPT_CTL_INVERT_OR_PULSE_SELECT 2
`define PPT_CTL_ONESHOT 3
`define PPT_CTL_LOAD    4
`define PPT_CTL_SRC_LO  5
`define PPT_CTL_SRC_HI  6

// ==========================================================================
// Interrupt status and mask fields
`define PPT_IRQ_TA      0
`define PPT_IRQ_TB      1
`define PPT_IRQ_FLAG    4
`define PPT_IRQ_SUMMARY 7
`define PPT_IRQ_SETCLR  7

// ==========================================================================
// Reset values and counts
`define PPT_LATCH_RST   16'hFFFF
`define PPT_BYTE_RST    8'h00
`define PPT_HS_DELAY    2'h3
`define PPT_TIMER_A_PIN 6
`define PPT_TIMER_B_PIN 7

`endif

/* File: design/ppt_pkg.sv */
// Types shared by the port and timer block.
package ppt_pkg;

    // ======================================================================
    // Count sources of a timer
    typedef enum logic [1:0] {
        PPT_SRC_PHASE,
        PPT_SRC_COUNT_PIN,
        PPT_SRC_CHAIN,
        PPT_SRC_CHAIN_GATED
    } ppt_src_t;

    typedef struct packed {
        ppt_src_t source;
        logic     one_shot;
        logic     invert_mode;
        logic     port_out;
        logic     run;
    } ppt_ctrl_t;

    typedef struct packed {
        logic [15:0] latch;
        logic [15:0] count;
        ppt_ctrl_t   ctrl;
        logic        toggle;
        logic        uf;
        logic        pb_level;
    } ppt_timer_state_t;

    typedef struct packed {
        logic stage1;
        logic stage2;
        logic prev;
        logic rise;
        logic fall;
    } ppt_edge_state_t;

    typedef struct packed {
        logic [7:0] port_a;
        logic [7:0] port_b;
        logic [7:0] dir_a;
        logic [7:0] dir_b;
        logic [7:0] status;
        logic [7:0] mask;
        logic       access;
        logic       phase_prev;
        logic [1:0] hs_count;
        logic       hs_strobe_n;
        logic       irq_oe_n;
        logic [7:0] bus_out;
        logic       bus_oe_n;
        logic [7:0] pa_out;
        logic [7:0] pa_oe_n;
        logic [7:0] pb_out;
        logic [7:0] pb_oe_n;
    } ppt_top_state_t;

endpackage : ppt_pkg

/* File: design/ppt_edge.sv */
// Two-stage synchroniser with rising and falling edge pulses.
`timescale 1ns/1ps
module ppt_edge
    import ppt_pkg::*;
(
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    ppt_edge_state_t s_q;
    ppt_edge_state_t s_d;

    // ======================================================================
    // Edges are taken from the second stage only, so the first flop never feeds logic.
    always_comb begin
        s_d        = s_q;
        s_d.stage1 = pin;
        s_d.stage2 = s_q.stage1;
        s_d.prev   = s_q.stage2;
        s_d.rise   = s_q.stage2 & ~s_q.prev;
        s_d.fall   = ~s_q.stage2 & s_q.prev;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{stage1: 1'b1, stage2: 1'b1, prev: 1'b1, rise: 1'b0, fall: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign level = s_q.prev;
    assign rise  = s_q.rise;
    assign fall  = s_q.fall;

endmodule : ppt_edge

/* File: design/ppt_timer.sv */
// One 16-bit interval timer with latch, control register and port output.
`timescale 1ns/1ps
`include "ppt_cfg.svh"
module ppt_timer
    import ppt_pkg::*;
#(
    parameter bit CHAINED = 1'b0
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        wr_low,
    input  wire logic        wr_high,
    input  wire logic        wr_ctrl,
    input  wire logic [7:0]  wdata,
    input  wire logic        phase_tick,
    input  wire logic        cnt_rise,
    input  wire logic        cnt_level,
    input  wire logic        chain_uf,
    output logic [15:0]      count,
    output logic [7:0]       ctrl_rd,
    output logic             underflow,
    output logic             port_out,
    output logic             pb_level
);
    ppt_timer_state_t s_q;
    ppt_timer_state_t s_d;
    logic             tick;
    logic             reload;
    logic             start;

    always_comb begin
        s_d    = s_q;
        reload = 1'b0;
        start  = 1'b0;
        s_d.uf = 1'b0;
        case (s_q.ctrl.source)
            PPT_SRC_PHASE:       tick = phase_tick;
            PPT_SRC_COUNT_PIN:   tick = cnt_rise;
            PPT_SRC_CHAIN:       tick = chain_uf;
            PPT_SRC_CHAIN_GATED: tick = chain_uf & cnt_level;
            default:             tick = 1'b0;
        endcase
        // Counting uses the run bit as it stood, so a host write takes effect next cycle.
        if (s_q.ctrl.run && tick) begin
            if (s_q.count == 16'h0000) begin
                s_d.uf = 1'b1;
                reload = 1'b1;
                if (s_q.ctrl.one_shot) begin
                    s_d.ctrl.run = 1'b0;
                end
            end else begin
                s_d.count = s_q.count - 16'h0001;
            end
        end
        if (wr_ctrl) begin
            s_d.ctrl.run         = wdata[`PPT_CTL_RUN];
            s_d.ctrl.port_out    = wdata[`PPT_CTL_PORTOUT];
            s_d.ctrl.invert_mode = wdata[`PPT_CTL_INVERT_OR_PULSE_SELECT];
            s_d.ctrl.one_shot    = wdata[`PPT_CTL_ONESHOT];
            s_d.ctrl.source      = CHAINED ? ppt_src_t'(wdata[`PPT_CTL_SRC_HI:`PPT_CTL_SRC_LO])
                                           : ppt_src_t'({1'b0, wdata[`PPT_CTL_SRC_LO]});
            start                = wdata[`PPT_CTL_RUN] & ~s_q.ctrl.run;
            if (wdata[`PPT_CTL_LOAD]) begin
                reload = 1'b1;
            end
        end
        if (wr_low) begin
            s_d.latch[7:0] = wdata;
        end
        if (wr_high) begin
            s_d.latch[15:8] = wdata;
            if (!s_q.ctrl.run) begin
                reload = 1'b1;
            end
            if (s_d.ctrl.one_shot) begin
                reload       = 1'b1;
                start        = ~s_q.ctrl.run;
                s_d.ctrl.run = 1'b1;
            end
        end
        if (reload) begin
            s_d.count = s_d.latch;
        end
        if (start) begin
            s_d.toggle = 1'b1;
        end else if (s_d.uf) begin
            s_d.toggle = ~s_q.toggle;
        end
        s_d.pb_level = s_d.ctrl.invert_mode ? s_d.toggle : s_d.uf;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{latch: `PPT_LATCH_RST, count: 16'h0000,
                     ctrl: '{source: PPT_SRC_PHASE, default: 1'b0},
                     toggle: 1'b0, uf: 1'b0, pb_level: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign count     = s_q.count;
    assign ctrl_rd   = {1'b0, s_q.ctrl.source[1], s_q.ctrl.source[0], 1'b0,
                        s_q.ctrl.one_shot, s_q.ctrl.invert_mode, s_q.ctrl.port_out,
                        s_q.ctrl.run};
    assign underflow = s_q.uf;
    assign port_out  = s_q.ctrl.port_out;
    assign pb_level  = s_q.pb_level;

endmodule : ppt_timer

/* File: design/ppt_top.sv */
// Peripheral port adapter with two 8-bit ports, handshake and two interval timers.
`timescale 1ns/1ps
`include "ppt_cfg.svh"
module ppt_top
    import ppt_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       phase_high,
    input  wire logic       chip_select_n,
    input  wire logic       read_write,
    input  wire logic [3:0] register_select,
    input  wire logic [7:0] bus_data_pins_in,
    output logic [7:0]      bus_data_pins_out,
    output logic            bus_data_pins_oe_n,
    output logic            irq_out,
    output logic            irq_oe_n,
    input  wire logic [7:0] port_a_pins_in,
    output logic [7:0]      port_a_pins_out,
    output logic [7:0]      port_a_pins_oe_n,
    input  wire logic [7:0] port_b_pins_in,
    output logic [7:0]      port_b_pins_out,
    output logic [7:0]      port_b_pins_oe_n,
    output logic            handshake_strobe_out,
    input  wire logic       handshake_flag_in,
    input  wire logic       count_pin
);
    ppt_top_state_t s_q;
    ppt_top_state_t s_d;

    // ======================================================================
    // Internal signals
    // Bus decode.
    logic        access;
    logic        new_access;
    logic        do_write;
    logic        do_read;
    logic        phase_tick;

    // Synchronised pins.
    logic        cnt_level;
    logic        cnt_rise;
    logic        flag_fall;

    // Timer results.
    logic [15:0] ta_count;
    logic [15:0] tb_count;
    logic [7:0]  ta_ctrl;
    logic [7:0]  tb_ctrl;
    logic        ta_uf;
    logic        tb_uf;
    logic        ta_port;
    logic        tb_port;
    logic        ta_level;
    logic        tb_level;

    // Timer write strobes.
    logic        wr_ta_low;
    logic        wr_ta_high;
    logic        wr_tb_low;
    logic        wr_tb_high;
    logic        wr_ctrl_a;
    logic        wr_ctrl_b;

    // Read data and pin drive.
    logic [7:0]  rdata;
    logic [7:0]  events;
    logic [7:0]  pb_drive;
    logic [7:0]  pb_dir;

    // ======================================================================
    // Bus access decode
    // An access is acted on once, at its first cycle, so a long phase-high window
    // never repeats a read side effect such as clearing the interrupt status.
    assign access     = ~chip_select_n & phase_high;
    assign new_access = access & ~s_q.access;
    assign do_write   = new_access & ~read_write;
    assign do_read    = new_access & read_write;
    // Each rising edge of the phase clock is one phase cycle.
    assign phase_tick = phase_high & ~s_q.phase_prev;

    // Write strobes for the timer registers.
    assign wr_ta_low  = do_write && (register_select == `PPT_OFS_TA_LOW);
    assign wr_ta_high = do_write && (register_select == `PPT_OFS_TA_HIGH);
    assign wr_tb_low  = do_write && (register_select == `PPT_OFS_TB_LOW);
    assign wr_tb_high = do_write && (register_select == `PPT_OFS_TB_HIGH);
    assign wr_ctrl_a  = do_write && (register_select == `PPT_OFS_CTRL_A);
    assign wr_ctrl_b  = do_write && (register_select == `PPT_OFS_CTRL_B);

    // ======================================================================
    // Pin synchronisers
    // The count pin fall and the flag rise and level are not needed.
    ppt_edge u_count_sync (
        .clock (clock),
        .nrst  (nrst),
        .pin   (count_pin),
        .level (cnt_level),
        .rise  (cnt_rise),
        .fall  ()
    );

    ppt_edge u_flag_sync (
        .clock (clock),
        .nrst  (nrst),
        .pin   (handshake_flag_in),
        .level (),
        .rise  (),
        .fall  (flag_fall)
    );

    // ======================================================================
    // Interval timers
    // Only timer B may count timer A underflows, so timer A has no chain.
    ppt_timer #(.CHAINED(1'b0)) u_timer_a (
        .clock      (clock),
        .nrst       (nrst),
        .wr_low     (wr_ta_low),
        .wr_high    (wr_ta_high),
        .wr_ctrl    (wr_ctrl_a),
        .wdata      (bus_data_pins_in),
        .phase_tick (phase_tick),
        .cnt_rise   (cnt_rise),
        .cnt_level  (cnt_level),
        .chain_uf   (1'b0),
        .count      (ta_count),
        .ctrl_rd    (ta_ctrl),
        .underflow  (ta_uf),
        .port_out   (ta_port),
        .pb_level   (ta_level)
    );

    ppt_timer #(.CHAINED(1'b1)) u_timer_b (
        .clock      (clock),
        .nrst       (nrst),
        .wr_low     (wr_tb_low),
        .wr_high    (wr_tb_high),
        .wr_ctrl    (wr_ctrl_b),
        .wdata      (bus_data_pins_in),
        .phase_tick (phase_tick),
        .cnt_rise   (cnt_rise),
        .cnt_level  (cnt_level),
        .chain_uf   (ta_uf),
        .count      (tb_count),
        .ctrl_rd    (tb_ctrl),
        .underflow  (tb_uf),
        .port_out   (tb_port),
        .pb_level   (tb_level)
    );

    // ======================================================================
    // Read multiplexer
    // Timer reads show the live counter with no snapshot, so a two-byte read
    // can straddle a borrow; read the high byte twice for a stable word.
    always_comb begin
        case (register_select)
            `PPT_OFS_PORT_A_DATA: rdata = port_a_pins_in;
            `PPT_OFS_PORT_B_DATA: rdata = port_b_pins_in;
            `PPT_OFS_PORT_A_DIR:  rdata = s_q.dir_a;
            `PPT_OFS_PORT_B_DIR:  rdata = s_q.dir_b;
            `PPT_OFS_TA_LOW:      rdata = ta_count[7:0];
            `PPT_OFS_TA_HIGH:     rdata = ta_count[15:8];
            `PPT_OFS_TB_LOW:      rdata = tb_count[7:0];
            `PPT_OFS_TB_HIGH:     rdata = tb_count[15:8];
            `PPT_OFS_IRQ:         rdata = s_q.status;
            `PPT_OFS_CTRL_A:      rdata = ta_ctrl;
            `PPT_OFS_CTRL_B:      rdata = tb_ctrl;
            default:              rdata = 8'h00;
        endcase
    end

    // ======================================================================
    // Port B pin drive with timer overrides
    // A timer output takes its pin over whatever its direction bit says.
    always_comb begin
        pb_drive = s_q.port_b;
        pb_dir   = s_q.dir_b;
        if (ta_port) begin
            pb_drive[`PPT_TIMER_A_PIN] = ta_level;
            pb_dir[`PPT_TIMER_A_PIN]   = 1'b1;
        end
        if (tb_port) begin
            pb_drive[`PPT_TIMER_B_PIN] = tb_level;
            pb_dir[`PPT_TIMER_B_PIN]   = 1'b1;
        end
    end

    // ======================================================================
    // Next state
    always_comb begin
        s_d            = s_q;
        s_d.access     = access;
        s_d.phase_prev = phase_high;
        events         = 8'h00;
        events[`PPT_IRQ_TA]   = ta_uf;
        events[`PPT_IRQ_TB]   = tb_uf;
        events[`PPT_IRQ_FLAG] = flag_fall;

        if (do_write) begin
            case (register_select)
                `PPT_OFS_PORT_A_DATA: s_d.port_a = bus_data_pins_in;
                `PPT_OFS_PORT_B_DATA: s_d.port_b = bus_data_pins_in;
                `PPT_OFS_PORT_A_DIR:  s_d.dir_a  = bus_data_pins_in;
                `PPT_OFS_PORT_B_DIR:  s_d.dir_b  = bus_data_pins_in;
                `PPT_OFS_IRQ: begin
                    // Only mask bits written as one change; bit 7 picks set or clear.
                    if (bus_data_pins_in[`PPT_IRQ_SETCLR]) begin
                        s_d.mask = s_q.mask | {1'b0, bus_data_pins_in[6:0]};
                    end else begin
                        s_d.mask = s_q.mask & ~{1'b0, bus_data_pins_in[6:0]};
                    end
                end
                default: s_d.mask = s_q.mask;
            endcase
        end

        // A status read clears, but an event in the same cycle still lands.
        if (do_read && register_select == `PPT_OFS_IRQ) begin
            s_d.status = events;
        end else begin
            s_d.status = s_q.status | events;
        end
        // The summary and the line follow the status in the same clock.
        s_d.status[`PPT_IRQ_SUMMARY] = |(s_d.status[6:0] & s_d.mask[6:0]);
        s_d.irq_oe_n = ~s_d.status[`PPT_IRQ_SUMMARY];

        // The strobe counts phase cycles, so it is blind to the fast clock rate.
        if (new_access && register_select == `PPT_OFS_PORT_B_DATA) begin
            s_d.hs_count    = `PPT_HS_DELAY;
            s_d.hs_strobe_n = 1'b1;
        end else if (phase_tick) begin
            s_d.hs_strobe_n = ~(s_q.hs_count == 2'h1);
            if (s_q.hs_count != 2'h0) begin
                s_d.hs_count = s_q.hs_count - 2'h1;
            end
        end

        // Read data is registered, so it follows the access by one clock.
        s_d.bus_out  = (access & read_write) ? rdata : s_q.bus_out;
        s_d.bus_oe_n = ~(access & read_write);

        // Port A pins take the next register values, so they change with the registers; port B pins follow them one clock later.
        s_d.pa_out   = s_d.port_a;
        s_d.pa_oe_n  = ~s_d.dir_a;
        s_d.pb_out   = pb_drive;
        s_d.pb_oe_n  = ~pb_dir;
    end

    // Reset releases every port pin, the bus and the interrupt line, and drives the handshake strobe high.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{port_a: `PPT_BYTE_RST, port_b: `PPT_BYTE_RST,
                     dir_a: `PPT_BYTE_RST, dir_b: `PPT_BYTE_RST,
                     status: `PPT_BYTE_RST, mask: `PPT_BYTE_RST,
                     access: 1'b0, phase_prev: 1'b0, hs_count: 2'h0,
                     hs_strobe_n: 1'b1, irq_oe_n: 1'b1, bus_out: 8'h00,
                     bus_oe_n: 1'b1, pa_out: 8'h00, pa_oe_n: 8'hFF,
                     pb_out: 8'h00, pb_oe_n: 8'hFF};
        end else begin
            s_q <= s_d;
        end
    end

    // ======================================================================
    // Outputs
    // The open-drain interrupt pin only ever pulls low, so its enable carries the request.
    assign bus_data_pins_out    = s_q.bus_out;
    assign bus_data_pins_oe_n   = s_q.bus_oe_n;
    assign irq_out              = 1'b0;
    assign irq_oe_n             = s_q.irq_oe_n;
    assign port_a_pins_out      = s_q.pa_out;
    assign port_a_pins_oe_n     = s_q.pa_oe_n;
    assign port_b_pins_out      = s_q.pb_out;
    assign port_b_pins_oe_n     = s_q.pb_oe_n;
    assign handshake_strobe_out = s_q.hs_strobe_n;

endmodule : ppt_top

/* File: dv/ppt_top_properties.sv */
// Concurrent checks on the bus, strobe and interrupt pins of the port timer block.
`timescale 1ns/1ps
module ppt_top_properties
    import ppt_pkg::*;
(
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic       phase_high,
    input wire logic       chip_select_n,
    input wire logic       read_write,
    input wire logic [3:0] register_select,
    input wire logic       bus_data_pins_oe_n,
    input wire logic       irq_out,
    input wire logic       irq_oe_n,
    input wire logic [7:0] port_a_pins_oe_n,
    input wire logic [7:0] port_b_pins_oe_n,
    input wire logic       handshake_strobe_out
);
    logic acc_q;
    wire  acc  = !chip_select_n && phase_high;
    wire  take = acc && !acc_q;

    // ======================================================================
    // Access edge tracking
    // Only the first cycle of a window acts, so repeats inside it are ignored.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            acc_q <= 1'b0;
        end else begin
            acc_q <= acc;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    // ======================================================================
    // Assertions
    a_read_drives_bus: assert property (take && read_write |=> !bus_data_pins_oe_n)
        else $error("bus not driven on a read");
    a_bus_only_read: assert property (!bus_data_pins_oe_n |-> $past(acc && read_write))
        else $error("bus driven outside a read");
    a_write_keeps_hiz: assert property (take && !read_write |=> bus_data_pins_oe_n)
        else $error("bus driven on a write");
    a_irq_open_drain: assert property (irq_out == 1'b0)
        else $error("interrupt pin drives high");
    a_status_read_release: assert property
        (take && read_write && register_select == 4'hD |=> irq_oe_n)
        else $error("interrupt line kept after status read");
    a_reset_all_inputs: assert property ($rose(nrst) |-> &port_a_pins_oe_n
        && &port_b_pins_oe_n && bus_data_pins_oe_n && irq_oe_n && handshake_strobe_out)
        else $error("pins not released by reset");
    a_strobe_third_phase: assert property (take && register_select == 4'h1
        |=> handshake_strobe_out[*8] ##[1:8] !handshake_strobe_out)
        else $error("strobe timing wrong");
    a_strobe_one_phase: assert property ($fell(handshake_strobe_out)
        |-> !handshake_strobe_out[*3] ##[1:2] handshake_strobe_out)
        else $error("strobe width wrong");

    c_status_read: cover property (take && read_write && register_select == 4'hD);
    c_irq_pulled: cover property ($fell(irq_oe_n));
    c_strobe: cover property ($fell(handshake_strobe_out));
endmodule : ppt_top_properties

bind ppt_top ppt_top_properties ppt_top_properties_i (.*);

/* File: dv/ppt_host.sv */
// Host processor model making the phase clock and register bus cycles.
`timescale 1ns/1ps
module ppt_host (
    input  wire logic       clock,
    input  wire logic       nrst,
    output logic            phase_high,
    output logic            chip_select_n,
    output logic            read_write,
    output logic [3:0]      register_select,
    output logic [7:0]      bus_data_pins_in,
    input  wire logic [7:0] bus_data_pins_out,
    input  wire logic       bus_data_pins_oe_n
);
    logic [1:0] pcnt_q;
    logic [7:0] wdata_q;

    assign phase_high = pcnt_q[1];
    // A released bus shows the inverse of the last value so stale data is not read.
    assign bus_data_pins_in = !bus_data_pins_oe_n ? bus_data_pins_out : wdata_q;

    initial begin
        chip_select_n   = 1'b1;
        read_write      = 1'b1;
        register_select = 4'h0;
        wdata_q         = 8'h00;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pcnt_q <= 2'h0;
        end else begin
            pcnt_q <= pcnt_q + 2'h1;
        end
    end

    // One access spans exactly one phase-high window, started while phase is low.
    task automatic access(input logic rw, input logic [3:0] sel, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge clock);
        while (pcnt_q != 2'h3) begin
            @(posedge clock);
        end
        chip_select_n   <= 1'b0;
        read_write      <= rw;
        register_select <= sel;
        wdata_q         <= d;
        repeat (4) @(posedge clock);
        q = bus_data_pins_out;
        chip_select_n <= 1'b1;
        wdata_q       <= ~d;
    endtask : access
endmodule : ppt_host

/* File: dv/test_ppt_top.sv */
// Self-checking bench for the port and timer block.
`timescale 1ns/1ps
module test_ppt_top;
    import ppt_pkg::*;
    logic       clock, nrst, flag, cnt, phase, cs_n, rw, bd_oe_n, irq_out, irq_oe_n, strobe;
    logic [3:0] sel;
    logic [7:0] bdin, bdout, pa_out, pa_oe_n, pb_out, pb_oe_n, q;
    wire  [7:0] pa_in = (pa_oe_n & 8'h3C) | (~pa_oe_n & pa_out);
    wire  [7:0] pb_in = pb_oe_n | (~pb_oe_n & pb_out);
    int         bad_count, compares, n;
    logic [19:0] rows [6] = '{20'h20F0F, 20'h3F0F0, 20'h0A535, 20'h85500, 20'hCAA00,
                              20'hE0C0C};

    ppt_host ppt_host_i (.clock(clock), .nrst(nrst), .phase_high(phase),
        .chip_select_n(cs_n), .read_write(rw), .register_select(sel),
        .bus_data_pins_in(bdin), .bus_data_pins_out(bdout), .bus_data_pins_oe_n(bd_oe_n));

    ppt_top ppt_top_i (.clock(clock), .nrst(nrst), .phase_high(phase),
        .chip_select_n(cs_n), .read_write(rw), .register_select(sel),
        .bus_data_pins_in(bdin), .bus_data_pins_out(bdout), .bus_data_pins_oe_n(bd_oe_n),
        .irq_out(irq_out), .irq_oe_n(irq_oe_n), .port_a_pins_in(pa_in),
        .port_a_pins_out(pa_out), .port_a_pins_oe_n(pa_oe_n), .port_b_pins_in(pb_in),
        .port_b_pins_out(pb_out), .port_b_pins_oe_n(pb_oe_n),
        .handshake_strobe_out(strobe), .handshake_flag_in(flag), .count_pin(cnt));

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check8

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        ppt_host_i.access(1'b0, a, d, q);
    endtask : wr

    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        ppt_host_i.access(1'b1, a, 8'h00, q);
        check8(q, e);
    endtask : rdc

    task automatic do_reset();
        nrst <= 1'b0;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
    endtask : do_reset

    task automatic give_verdict();
        if (bad_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // The whole sequence needs under 1500 clocks.
    initial begin
        #(50 * 4000);
        bad_count++;
        give_verdict();
    end

    initial begin
        nrst = 1'b0;
        flag = 1'b1;
        cnt  = 1'b0;
        do_reset();
        // ==================================================================
        // Register table
        for (int i = 0; i < 6; i++) begin
            wr(rows[i][19:16], rows[i][15:8]);
            rdc(rows[i][19:16], rows[i][7:0]);
        end
        check8(pa_oe_n, 8'hF0);
        // ==================================================================
        // Timer A one-shot started by the high byte write
        wr(4'hE, 8'h0A);
        wr(4'hD, 8'h81);
        wr(4'h4, 8'h03);
        wr(4'h5, 8'h00);
        check8({7'h00, pb_oe_n[6]}, 8'h00);
        n = 0;
        while (irq_oe_n !== 1'b0 && n < 80) begin
            @(posedge clock);
            n++;
        end
        check8({7'h00, irq_oe_n}, 8'h00);
        rdc(4'hD, 8'h81);
        check8({7'h00, irq_oe_n}, 8'h01);
        rdc(4'hE, 8'h0A);
        rdc(4'h4, 8'h03);
        // ==================================================================
        // Timer B continuous on count pin pulses
        wr(4'h6, 8'h02);
        wr(4'h7, 8'h00);
        rdc(4'h6, 8'h02);
        wr(4'hF, 8'h21);
        repeat (4) begin
            cnt <= 1'b1;
            repeat (4) @(posedge clock);
            cnt <= 1'b0;
            repeat (4) @(posedge clock);
        end
        rdc(4'hD, 8'h02);
        rdc(4'h6, 8'h01);
        wr(4'hF, 8'h31);
        rdc(4'h6, 8'h02);
        rdc(4'hF, 8'h21);
        // ==================================================================
        // Word handshake: port A first, then port B marks completion
        wr(4'h0, 8'h11);
        wr(4'h1, 8'h5A);
        n = 0;
        while (strobe !== 1'b0 && n < 40) begin
            @(posedge clock);
            n++;
        end
        check8({7'h00, strobe}, 8'h00);
        repeat (8) @(posedge clock);
        rdc(4'h1, 8'h1F);
        flag <= 1'b0;
        repeat (8) @(posedge clock);
        rdc(4'hD, 8'h10);
        // ==================================================================
        // Timer A toggling on port B bit six, timer B counting its underflows
        wr(4'hE, 8'h06);
        wr(4'h4, 8'h01);
        wr(4'h5, 8'h00);
        wr(4'hF, 8'h41);
        wr(4'hE, 8'h07);
        @(posedge clock);
        check8({7'h00, pb_out[6]}, 8'h01);
        repeat (8) @(posedge clock);
        check8({7'h00, pb_out[6]}, 8'h00);
        repeat (8) @(posedge clock);
        check8({7'h00, pb_out[6]}, 8'h01);
        repeat (8) @(posedge clock);
        rdc(4'hD, 8'h83);
        // ==================================================================
        // Reset in mid-run
        flag <= 1'b1;
        repeat (20) @(posedge clock);
        do_reset();
        @(posedge clock);
        check8(pa_oe_n, 8'hFF);
        check8(pb_oe_n, 8'hFF);
        rdc(4'h2, 8'h00);
        wr(4'hE, 8'h10);
        rdc(4'h5, 8'hFF);
        give_verdict();
    end
endmodule : test_ppt_top
